// [rtl/txport_pkg.sv]
// Constants and types for the expansion port transmit side
package txport_pkg;
  // Strap field layout on the four data pins
  localparam int          STRAP_W        = 4;
  localparam int          STRAP_PHY_BIT  = 3;
  localparam int          STRAP_SEL_HI   = 1;
  localparam int          STRAP_SEL_LO   = 0;
  localparam logic [1:0]  SEL_MII100     = 2'h0;
  localparam logic [1:0]  SEL_MII10      = 2'h1;
  localparam logic [1:0]  SEL_RMII       = 2'h2;
  localparam logic [1:0]  SEL_SNI        = 2'h3;
  localparam int          STRAP_FDX_BIT  = 2;
  // Link clock rates
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          RATE_100_HZ    = 25_000_000;
  localparam int          RATE_10_HZ     = 2_500_000;
  localparam int          RATE_RMII_HZ   = 50_000_000;
  // Half periods in system cycles, never below one
  localparam int          HALF_10_CYC    = (CLK_HZ / RATE_10_HZ / 2 < 1) ? 1
                                           : CLK_HZ / RATE_10_HZ / 2;
  localparam int          HALF_100_CYC   = (CLK_HZ / RATE_100_HZ / 2 < 1) ? 1
                                           : CLK_HZ / RATE_100_HZ / 2;
  localparam int          HALF_RMII_CYC  = (CLK_HZ / RATE_RMII_HZ / 2 < 1) ? 1
                                           : CLK_HZ / RATE_RMII_HZ / 2;
  localparam int          DIV_W          = 8;
  localparam logic [3:0]  NIBBLE_IDLE    = 4'h0;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          FIFO_WIDTH     = 4;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_TAIL = 3'b100
  } tx_state_type;
endpackage : txport_pkg

// [rtl/nibble_if.sv]
// Stream carrier between transmit core and its FIFO
`timescale 1ns/100ps
interface nibble_if #(parameter int W = 4);
  logic [W-1:0] data;
  logic         last;
  logic         valid;
  logic         ready;
  modport source (output data, output last, output valid, input ready);
  modport sink   (input data, input last, input valid, output ready);
endinterface : nibble_if

// [rtl/nibble_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module nibble_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  nibble_if.sink    wr,
  nibble_if.source  rd
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("nibble_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH:0] mem [DEPTH];
  logic [AW:0]    wptr_reg;
  logic [AW:0]    rptr_reg;
  wire            full_w  = (wptr_reg[AW] != rptr_reg[AW]) &&
                            (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  wire            empty_w = (wptr_reg == rptr_reg);
  wire            push_w  = wr.valid && !full_w;
  wire            pop_w   = rd.ready && !empty_w;

  assign wr.ready = !full_w;
  assign rd.valid = !empty_w;
  assign rd.data  = mem[rptr_reg[AW-1:0]][WIDTH-1:0];
  assign rd.last  = mem[rptr_reg[AW-1:0]][WIDTH];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (ce) begin
      if (push_w) wptr_reg <= wptr_reg + 1'b1;
      if (pop_w) rptr_reg <= rptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push_w) mem[wptr_reg[AW-1:0]] <= {wr.last, wr.data};
  end
endmodule : nibble_fifo

// [rtl/port_tx_side.sv]
// Expansion port transmit pins: strap capture, clock, data, carrier sense, collision
`timescale 1ns/100ps
// Behaviour
// - Tx clock pin direction follows captured strap
// - PHY mode drives 25, 2.5 or 50 MHz; code gives 10, 2.5 or 10 MHz
// - Tx clock pin floats during reset
// - Tx data pins driven after reset while port enabled
// - SNI mode: only bit zero meaningful
// - RMII mode: only lower two bits
// - Data pins float during reset, sampled as strap
// - Tx valid marks valid frame data
// - Tx valid pin floats during reset
// - Carrier sense output only in PHY
// - Carrier sense follows receive activity
// - Half duplex: carrier during transmission
// - Carrier and collision synchronised on input
// - Carrier sense pin floats during reset
// - Collision output only in PHY mode
// - PHY collision when both paths busy
// - Full duplex MAC ignores collision input
// - Collision pin floats during reset
// - Select high: MII off, PHY on
// - Enable low tri-states whole port
module port_tx_side
  import txport_pkg::*;
#(
  parameter int DATA_W = FIFO_WIDTH,
  parameter int DEPTH  = FIFO_DEPTH
) (
  input  wire logic         MCLK,
  input  wire logic         NRST,
  input  wire logic         CE,
  // Frame source inside the switch
  input  wire logic [3:0]   TX_NIBBLE,
  input  wire logic         TX_LAST,
  input  wire logic         TX_VALID,
  output logic              TX_READY,
  input  wire logic         RX_BUSY,
  output logic              COLLISION_SEEN,
  output logic              PHY_MODE,
  output logic [1:0]        IFACE_SEL,
  output logic              FULL_DUPLEX,
  // Port enables and second port select
  input  wire logic         EXPANSION_PORT_ENABLE,
  input  wire logic         SECOND_PORT_IFACE_SELECT,
  output logic              SECOND_PORT_MII_EN,
  output logic              SECOND_PORT_PHY_EN,
  // Transmit clock pin
  input  wire logic         PORT_TX_CLOCK_I,
  output logic              PORT_TX_CLOCK_O,
  output logic              PORT_TX_CLOCK_OE,
  // Data / strap pins
  input  wire logic [3:0]   PORT_TX_DATA_I,
  output logic [3:0]        PORT_TX_DATA_O,
  output logic              PORT_TX_DATA_OE,
  output logic              PORT_TX_VALID_O,
  output logic              PORT_TX_VALID_OE,
  // Carrier sense and collision pins
  input  wire logic         PORT_CARRIER_SENSE_I,
  output logic              PORT_CARRIER_SENSE_O,
  output logic              PORT_CARRIER_SENSE_OE,
  input  wire logic         PORT_COLLISION_I,
  output logic              PORT_COLLISION_O,
  output logic              PORT_COLLISION_OE
);
  initial begin
    if (DATA_W != 4 || DEPTH < 2)
      $error("port_tx_side: DATA_W must be 4 and DEPTH at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] strap_s1_reg;
  logic [3:0] strap_s2_reg;
  logic       clk_s1_reg;
  logic       clk_s2_reg;
  logic       clk_d_reg;
  logic       crs_s1_reg;
  logic       crs_s2_reg;
  logic       col_s1_reg;
  logic       col_s2_reg;
  logic       en_s1_reg;
  logic       en_s2_reg;
  logic       sel_s1_reg;
  logic       sel_s2_reg;

  // Synchronisers run through reset so the strap is settled at release
  always_ff @(posedge MCLK) begin
    if (CE) begin
      strap_s1_reg <= PORT_TX_DATA_I;
      strap_s2_reg <= strap_s1_reg;
      clk_s1_reg   <= PORT_TX_CLOCK_I;
      clk_s2_reg   <= clk_s1_reg;
      crs_s1_reg   <= PORT_CARRIER_SENSE_I;
      crs_s2_reg   <= crs_s1_reg;
      col_s1_reg   <= PORT_COLLISION_I;
      col_s2_reg   <= col_s1_reg;
      en_s1_reg    <= EXPANSION_PORT_ENABLE;
      en_s2_reg    <= en_s1_reg;
      sel_s1_reg   <= SECOND_PORT_IFACE_SELECT;
      sel_s2_reg   <= sel_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture
  logic [3:0] strap_reg;
  logic       run_reg;

  // Strap tracks pins while in reset and on the first cycle out of it, frozen after that
  always_ff @(posedge MCLK) begin
    if (CE) begin
      if (!NRST) begin
        run_reg <= 1'b0;
      end else begin
        run_reg <= 1'b1;
      end
      if (!NRST || !run_reg) strap_reg <= strap_s2_reg;
    end
  end

  wire       phy_w    = strap_reg[STRAP_PHY_BIT];
  wire [1:0] sel_w    = strap_reg[STRAP_SEL_HI:STRAP_SEL_LO];
  wire       fdx_w    = strap_reg[STRAP_FDX_BIT];
  wire       active_w = run_reg && en_s2_reg;
  wire       is_rmii  = (sel_w == SEL_RMII);
  wire       is_sni   = (sel_w == SEL_SNI);

  assign PHY_MODE    = phy_w;
  assign IFACE_SEL   = sel_w;
  assign FULL_DUPLEX = fdx_w;

  ////////////////////////////////////////////////////////////////////////////
  // Clock generation in PHY mode, edge detection in MAC mode
  logic [DIV_W-1:0] div_reg;
  logic             gen_clk_reg;
  wire  [DIV_W-1:0] half_w = is_rmii ? DIV_W'(HALF_RMII_CYC) :
                             (sel_w == SEL_MII100) ? DIV_W'(HALF_100_CYC) :
                             DIV_W'(HALF_10_CYC);
  wire              div_end_w = (div_reg >= half_w - 1'b1);

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      div_reg     <= '0;
      gen_clk_reg <= 1'b0;
      // Idle level of the pulled-up clock pin, so no false edge follows reset
      clk_d_reg   <= 1'b1;
    end else if (CE) begin
      clk_d_reg <= clk_s2_reg;
      if (div_end_w) begin
        div_reg     <= '0;
        gen_clk_reg <= !gen_clk_reg;
      end else begin
        div_reg <= div_reg + 1'b1;
      end
    end
  end

  // Fast rates exceed MCLK; the generated clock then runs at MCLK/2, a limitation
  wire gen_rise_w = div_end_w && !gen_clk_reg;
  wire ext_rise_w = clk_s2_reg && !clk_d_reg;
  wire tick_w     = phy_w ? gen_rise_w : ext_rise_w;

  ////////////////////////////////////////////////////////////////////////////
  // FIFO in the data path
  nibble_if #(.W(DATA_W)) fifo_in ();
  nibble_if #(.W(DATA_W)) fifo_out ();

  assign fifo_in.data  = TX_NIBBLE;
  assign fifo_in.last  = TX_LAST;
  assign fifo_in.valid = TX_VALID && active_w;
  assign TX_READY      = fifo_in.ready && active_w;

  nibble_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk   (MCLK),
    .rst_n (NRST),
    .ce    (CE),
    .wr    (fifo_in.sink),
    .rd    (fifo_out.source)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequencer, one FIFO entry per link clock rising edge
  tx_state_type state_reg;
  tx_state_type state_next;
  logic [3:0]   data_reg;
  logic         valid_reg;

  wire take_w = tick_w && fifo_out.valid && active_w;
  assign fifo_out.ready = take_w;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TX_IDLE: if (take_w) state_next = fifo_out.last ? TX_TAIL : TX_SEND;
      TX_SEND: if (take_w && fifo_out.last) state_next = TX_TAIL;
      TX_TAIL: if (tick_w) state_next = take_w ? (fifo_out.last ? TX_TAIL : TX_SEND)
                                               : TX_IDLE;
    endcase
  end

  // Lane masking keeps unused bits quiet in narrow modes
  wire [3:0] lane_w = is_sni  ? {3'h0, fifo_out.data[0]} :
                      is_rmii ? {2'h0, fifo_out.data[1:0]} :
                      fifo_out.data;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state_reg <= TX_IDLE;
      data_reg  <= NIBBLE_IDLE;
      valid_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      if (!active_w) begin
        data_reg  <= NIBBLE_IDLE;
        valid_reg <= 1'b0;
      end else if (tick_w) begin
        data_reg  <= take_w ? lane_w : NIBBLE_IDLE;
        valid_reg <= take_w;
      end
    end
  end

  wire tx_busy_w = valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier sense and collision
  logic crs_reg;
  logic col_reg;
  wire  crs_w = RX_BUSY || (!fdx_w && tx_busy_w);
  wire  col_w = RX_BUSY && tx_busy_w;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else if (CE) begin
      crs_reg <= crs_w;
      col_reg <= col_w;
    end
  end

  // MAC mode: partner reports collision; ignored in full duplex
  assign COLLISION_SEEN = phy_w ? col_reg : (col_s2_reg && !fdx_w && active_w);

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all released while in reset or disabled
  wire drive_w = NRST && active_w;

  assign PORT_TX_CLOCK_O       = gen_clk_reg;
  assign PORT_TX_CLOCK_OE      = drive_w && phy_w;
  assign PORT_TX_DATA_O        = data_reg;
  assign PORT_TX_DATA_OE       = drive_w;
  assign PORT_TX_VALID_O       = valid_reg;
  assign PORT_TX_VALID_OE      = drive_w;
  assign PORT_CARRIER_SENSE_O  = crs_reg;
  assign PORT_CARRIER_SENSE_OE = drive_w && phy_w;
  assign PORT_COLLISION_O      = col_reg;
  assign PORT_COLLISION_OE     = drive_w && phy_w;

  // Second port select: high hands the port to the internal PHY
  assign SECOND_PORT_MII_EN = !sel_s2_reg;
  assign SECOND_PORT_PHY_EN = sel_s2_reg;
endmodule : port_tx_side

// [test/port_tx_side_assertions.sv]
// Checker for the expansion port transmit pins
`timescale 1ns/100ps
module port_tx_side_assertions
  import txport_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       NRST,
  input wire logic       RX_BUSY,
  input wire logic       PHY_MODE,
  input wire logic [1:0] IFACE_SEL,
  input wire logic       SECOND_PORT_MII_EN,
  input wire logic       SECOND_PORT_PHY_EN,
  input wire logic       PORT_TX_CLOCK_OE,
  input wire logic [3:0] PORT_TX_DATA_O,
  input wire logic       PORT_TX_DATA_OE,
  input wire logic       PORT_TX_VALID_O,
  input wire logic       PORT_TX_VALID_OE,
  input wire logic       PORT_CARRIER_SENSE_O,
  input wire logic       PORT_CARRIER_SENSE_OE,
  input wire logic       PORT_COLLISION_O,
  input wire logic       PORT_COLLISION_OE
);
  default clocking cb @(posedge MCLK); endclocking
  ////////////////////////////////////////////////////////////////////////////////
  AST_RST_FLOAT: assert property (
    !NRST |-> !(PORT_TX_CLOCK_OE | PORT_TX_DATA_OE | PORT_TX_VALID_OE
      | PORT_CARRIER_SENSE_OE | PORT_COLLISION_OE)) else $error("Pin driven in reset");
  AST_CLK_DIR: assert property (disable iff (!NRST)
    PORT_TX_CLOCK_OE |-> PHY_MODE) else $error("Clock driven in MAC mode");
  AST_CRS_DIR: assert property (disable iff (!NRST)
    PORT_CARRIER_SENSE_OE |-> PHY_MODE) else $error("Carrier driven in MAC mode");
  AST_COL_DIR: assert property (disable iff (!NRST)
    PORT_COLLISION_OE |-> PHY_MODE) else $error("Collision driven in MAC mode");
  AST_SNI: assert property (disable iff (!NRST)
    PORT_TX_DATA_OE && IFACE_SEL == SEL_SNI |-> PORT_TX_DATA_O[3:1] == 3'h0)
    else $error("Serial mode upper bits busy");
  AST_RMII: assert property (disable iff (!NRST)
    PORT_TX_DATA_OE && IFACE_SEL == SEL_RMII |-> PORT_TX_DATA_O[3:2] == 2'h0)
    else $error("Reduced mode upper bits busy");
  AST_IDLE_DATA: assert property (disable iff (!NRST)
    !PORT_TX_VALID_O |-> PORT_TX_DATA_O == 4'h0) else $error("Data without valid");
  AST_CRS_RX: assert property (disable iff (!NRST)
    PORT_CARRIER_SENSE_OE && RX_BUSY |=> PORT_CARRIER_SENSE_O)
    else $error("Carrier missing on receive");
  AST_COL_CAUSE: assert property (disable iff (!NRST)
    PORT_COLLISION_O |-> $past(RX_BUSY)) else $error("Collision without receive");
  AST_STRAP_HOLD: assert property (disable iff (!NRST)
    PORT_TX_DATA_OE && $past(PORT_TX_DATA_OE) |-> $stable(PHY_MODE) && $stable(IFACE_SEL))
    else $error("Mode changed after reset");
  AST_SEL: assert property (disable iff (!NRST)
    SECOND_PORT_MII_EN != SECOND_PORT_PHY_EN) else $error("Second port select clash");
  ////////////////////////////////////////////////////////////////////////////////
  COV_RMII: cover property (PORT_TX_VALID_O && IFACE_SEL == SEL_RMII);
  COV_COL: cover property (PORT_COLLISION_O);
  COV_MAC: cover property (PORT_TX_VALID_O && !PHY_MODE);
endmodule : port_tx_side_assertions

bind port_tx_side port_tx_side_assertions u_port_tx_side_assertions (.*);

// [test/far_end_model.sv]
// Far-side MAC or PHY model with pin pulls and strap levels
`timescale 1ns/100ps
module far_end_model (
  input  wire logic       NRST,
  input  wire logic [3:0] strap,
  input  wire logic       mac_run,
  input  wire logic       crs_drv,
  input  wire logic       col_drv,
  input  wire logic       PORT_TX_CLOCK_O,
  input  wire logic       PORT_TX_CLOCK_OE,
  output logic            PORT_TX_CLOCK_I,
  input  wire logic [3:0] PORT_TX_DATA_O,
  input  wire logic       PORT_TX_DATA_OE,
  output logic [3:0]      PORT_TX_DATA_I,
  input  wire logic       PORT_CARRIER_SENSE_O,
  input  wire logic       PORT_CARRIER_SENSE_OE,
  output logic            PORT_CARRIER_SENSE_I,
  input  wire logic       PORT_COLLISION_O,
  input  wire logic       PORT_COLLISION_OE,
  output logic            PORT_COLLISION_I
);
  logic link_clk = 1'b1;
  // Odd start offset keeps the link clock out of phase with MCLK; idle level is the pull-up
  initial begin
    #13;
    forever #200 link_clk = mac_run ? ~link_clk : 1'b1;
  end
  assign PORT_TX_CLOCK_I = PORT_TX_CLOCK_OE ? PORT_TX_CLOCK_O : link_clk;
  // Board straps during reset, pull-ups otherwise
  assign PORT_TX_DATA_I = PORT_TX_DATA_OE ? PORT_TX_DATA_O : (NRST ? 4'hF : strap);
  // Pull-downs when nobody drives; far-side levels are asynchronous
  assign PORT_CARRIER_SENSE_I = PORT_CARRIER_SENSE_OE ? PORT_CARRIER_SENSE_O : crs_drv;
  assign PORT_COLLISION_I = PORT_COLLISION_OE ? PORT_COLLISION_O : col_drv;
endmodule : far_end_model

// [test/tb_port_tx_side.sv]
// Self-checking bench for the expansion port transmit side
`timescale 1ns/100ps
module tb_port_tx_side import txport_pkg::*;;
  logic       MCLK = 1'b0, NRST = 1'b0, CE = 1'b1, TX_LAST = 1'b0, TX_VALID = 1'b0;
  logic       RX_BUSY = 1'b0, EXPANSION_PORT_ENABLE = 1'b1, SECOND_PORT_IFACE_SELECT = 1'b0;
  logic [3:0] TX_NIBBLE = 4'h0, strap = 4'h0;
  logic       mac_run = 1'b0, crs_drv = 1'b0, col_drv = 1'b0, crs_seen, col_seen, c;
  logic       TX_READY, COLLISION_SEEN, PHY_MODE, FULL_DUPLEX;
  logic       SECOND_PORT_MII_EN, SECOND_PORT_PHY_EN, PORT_TX_CLOCK_O, PORT_TX_CLOCK_OE;
  logic       PORT_TX_DATA_OE, PORT_TX_VALID_O, PORT_TX_VALID_OE;
  logic       PORT_CARRIER_SENSE_O, PORT_CARRIER_SENSE_OE, PORT_COLLISION_O, PORT_COLLISION_OE;
  logic [1:0] IFACE_SEL;
  logic [3:0] PORT_TX_DATA_O;
  wire        PORT_TX_CLOCK_I, PORT_CARRIER_SENSE_I, PORT_COLLISION_I;
  wire  [3:0] PORT_TX_DATA_I;
  int         n_mismatch = 0, compares = 0;

  port_tx_side u_port_tx_side (.*);
  far_end_model u_far_end_model (.*);

  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    crs_seen |= PORT_CARRIER_SENSE_O;
    col_seen |= PORT_COLLISION_O;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic do_reset(input logic [3:0] s);
    @(posedge MCLK);
    NRST <= 1'b0;
    strap <= s;
    repeat (20) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (4) @(posedge MCLK);
  endtask : do_reset

  // One nibble frame, then wait for it on the pins
  task automatic send(input logic [3:0] n, input logic [3:0] exp);
    int k;
    @(posedge MCLK);
    TX_NIBBLE <= n;
    TX_LAST <= 1'b1;
    TX_VALID <= 1'b1;
    k = 0;
    do begin
      @(negedge MCLK);
      k++;
    end while (TX_READY !== 1'b1 && k < 50);
    @(posedge MCLK);
    TX_VALID <= 1'b0;
    k = 0;
    while (PORT_TX_VALID_O !== 1'b1 && k < 200) begin
      @(negedge MCLK);
      k++;
    end
    chk("tx data", PORT_TX_DATA_O, exp);
  endtask : send
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_phy_rmii;
    do_reset(4'hA);
    @(negedge MCLK);
    chk("mode", {PHY_MODE, FULL_DUPLEX, IFACE_SEL}, 4'hA);
    chk("pin oe", {PORT_TX_CLOCK_OE, PORT_TX_DATA_OE, PORT_CARRIER_SENSE_OE,
      PORT_COLLISION_OE}, 4'hF);
    c = PORT_TX_CLOCK_O;
    @(negedge MCLK);
    chk("clock toggle", {3'h0, PORT_TX_CLOCK_O}, {3'h0, ~c});
    crs_seen = 1'b0;
    send(4'hF, 4'h3);
    repeat (2) @(negedge MCLK);
    chk("carrier on tx", {3'h0, crs_seen}, 4'h1);
    @(posedge MCLK);
    RX_BUSY <= 1'b1;
    col_seen = 1'b0;
    send(4'h6, 4'h2);
    repeat (2) @(negedge MCLK);
    chk("collision", {3'h0, col_seen}, 4'h1);
    chk("carrier on rx", {3'h0, PORT_CARRIER_SENSE_O}, 4'h1);
    @(posedge MCLK);
    RX_BUSY <= 1'b0;
  endtask : t_phy_rmii

  task automatic t_enable_select;
    @(posedge MCLK);
    EXPANSION_PORT_ENABLE <= 1'b0;
    SECOND_PORT_IFACE_SELECT <= 1'b1;
    repeat (4) @(negedge MCLK);
    chk("port off", {TX_READY, PORT_TX_DATA_OE, PORT_TX_VALID_OE, PORT_TX_CLOCK_OE}, 4'h0);
    chk("select high", {2'h0, SECOND_PORT_MII_EN, SECOND_PORT_PHY_EN}, 4'h1);
    @(posedge MCLK);
    EXPANSION_PORT_ENABLE <= 1'b1;
    SECOND_PORT_IFACE_SELECT <= 1'b0;
    repeat (4) @(negedge MCLK);
    chk("select low", {2'h0, SECOND_PORT_MII_EN, SECOND_PORT_PHY_EN}, 4'h2);
  endtask : t_enable_select

  task automatic t_mac_sni;
    do_reset(4'h7);
    @(posedge MCLK);
    mac_run <= 1'b1;
    crs_drv <= 1'b1;
    col_drv <= 1'b1;
    @(negedge MCLK);
    chk("mode", {PHY_MODE, FULL_DUPLEX, IFACE_SEL}, 4'h7);
    chk("pin oe", {PORT_TX_CLOCK_OE, PORT_TX_DATA_OE, PORT_CARRIER_SENSE_OE,
      PORT_COLLISION_OE}, 4'h4);
    send(4'hB, 4'h1);
    chk("collision ignored", {3'h0, COLLISION_SEEN}, 4'h0);
    @(posedge MCLK);
    mac_run <= 1'b0;
    crs_drv <= 1'b0;
    col_drv <= 1'b0;
  endtask : t_mac_sni
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    t_phy_rmii();
    t_enable_select();
    t_mac_sni();
    report_and_stop();
  end

  // Whole run takes about a hundred cycles
  initial begin
    repeat (5000) @(posedge MCLK);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_port_tx_side
